// File: hw/t2_pkg.sv
// Constants and carrier types for the capture and clock-out timer
package t2_pkg;

   // *********************************************
   // Register offsets (register port, byte wide)
   // *********************************************
   localparam logic [3:0] ADDR_CONTROL = 4'h0;
   localparam logic [3:0] ADDR_MODE = 4'h1;
   localparam logic [3:0] ADDR_RELOAD_LOW = 4'h2;
   localparam logic [3:0] ADDR_RELOAD_HIGH = 4'h3;
   localparam logic [3:0] ADDR_COUNT_LOW = 4'h4;
   localparam logic [3:0] ADDR_COUNT_HIGH = 4'h5;
   localparam logic [3:0] ADDR_PIN_FUNC = 4'h6;
   localparam logic [3:0] ADDR_IRQ_STATUS = 4'h7;
   localparam logic [3:0] ADDR_IRQ_MASK = 4'h8;

   // *********************************************
   // Control and mode register bit positions
   // *********************************************
   localparam int BIT_OVERFLOW_FLAG = 7;
   localparam int BIT_EXTERNAL_FLAG = 6;
   localparam int BIT_EXT_TRIGGER_ENABLE = 3;
   localparam int BIT_RUN_CONTROL = 2;
   localparam int BIT_COUNT_SOURCE = 1;
   localparam int BIT_CAPTURE_RELOAD = 0;
   localparam int BIT_CLOCK_OUT_ENABLE = 1;

   // *********************************************
   // Reset values and encodings
   // *********************************************
   localparam logic [7:0] RESET_BYTE = 8'h00;
   localparam logic [15:0] RESET_WORD = 16'h0000;
   localparam logic [1:0] MODE_LOW_RESET = 2'h0;
   localparam logic [1:0] PIN_FUNC_CLOCK_OUT = 2'h2;
   localparam logic [15:0] COUNT_MAX = 16'hffff;
   localparam logic [2:0] IRQ_NONE = 3'h0;
   // Status bits: capture, capture-mode overflow, clock-out overflow
   localparam int IRQ_CAPTURE = 0;
   localparam int IRQ_OVERFLOW = 1;
   localparam int IRQ_TOGGLE = 2;

   // Internal count rate is the oscillator over two
   localparam int OSC_DIVIDE = 2;

   typedef enum logic [1:0] {
      MODE_IDLE = 2'b00,
      MODE_CAPTURE = 2'b01,
      MODE_CLOCK_OUT = 2'b10,
      MODE_RELOAD = 2'b11
   } timer_mode_t;

   // Register port request
   typedef struct packed {
      logic [3:0] addr;
      logic [7:0] wdata;
      logic wr;
      logic rd;
   } reg_req_t;

   // One-cycle timer events
   typedef struct packed {
      logic capture;
      logic overflow;
   } timer_event_t;

endpackage : t2_pkg

// File: hw/pin_edge_sync.sv
// Two-stage synchroniser with falling and rising edge pulses
`timescale 1ns/1ps
`default_nettype none
module pin_edge_sync (
   input wire logic clk_sys, // System clock
   input wire logic rstn, // Synchronous reset, active low
   input wire logic pin, // Asynchronous pin level
   output logic fall, // One-cycle high-to-low pulse
   output logic rise // One-cycle low-to-high pulse
);
   logic meta;
   logic sync;
   logic prev;

   // *********************************************
   // Synchroniser and edge compare
   // *********************************************
   // First stage read only by the second
   always_ff @(posedge clk_sys) begin
      if (!rstn) begin
         meta <= 1'b1;
         sync <= 1'b1;
         prev <= 1'b1;
      end else begin
         meta <= pin;
         sync <= meta;
         prev <= sync;
      end
   end

   assign fall = prev & ~sync;
   assign rise = ~prev & sync;
endmodule : pin_edge_sync
`default_nettype wire

// File: hw/rate_divider.sv
// Divider giving a one-cycle enable at the internal count rate
`timescale 1ns/1ps
`default_nettype none
module rate_divider #(
   parameter int DIVIDE = 2 // System clocks per enable pulse
) (
   input wire logic clk_sys, // System clock
   input wire logic rstn, // Synchronous reset, active low
   input wire logic run, // Divider runs while high
   output logic tick // One-cycle enable
);
   localparam int W = (DIVIDE > 1) ? $clog2(DIVIDE) : 1;
   localparam logic [W-1:0] LAST = W'(DIVIDE - 1);
   logic [W-1:0] cnt;

   // *********************************************
   // Free count while running
   // *********************************************
   always_ff @(posedge clk_sys) begin
      if (!rstn || !run) begin
         cnt <= '0;
      end else if (cnt == LAST) begin
         cnt <= '0;
      end else begin
         cnt <= cnt + W'(1);
      end
   end

   assign tick = run && (cnt == LAST);
endmodule : rate_divider
`default_nettype wire

// File: hw/timer2_capture_clock_out.sv
// Third timer: capture and programmable clock-out modes
`timescale 1ns/1ps
`default_nettype none
// How it works
// - Capture mode counts while capture select, trigger enable and run are all one.
// - In capture mode with run control one, a capture-pin falling edge captures the count and raises an interrupt.
// - Capture-mode counter overflow also raises an interrupt.
// - Clock-out mode needs capture select zero and clock-out enable one.
// - Clock-out reaches its pin only when pin function select is 10.
// - Count source: internal clock over two, or count input pin pulses.
// - Counter runs only while run control is one.
// - Clock-out overflow loads reload value into count.
// - Clock-out overflow inverts clock-out level, 50% duty.
// - Clock-out overflows raise no interrupt.
// - With the internal count source, output frequency is oscillator over 4 times (65536 minus reload).
// - Reset clears control, reload, count and low two mode bits.
// - Capture copies count to reload, sets external flag, counting continues.
// - Overflow flag is set on timer interrupt event, cleared only by writing zero.
module timer2_capture_clock_out
   import t2_pkg::*;
#(
   parameter int OSC_DIV = OSC_DIVIDE // System clocks per internal count
) (
   input wire logic clk_sys, // System clock, 100 MHz
   input wire logic rstn, // Synchronous reset, active low
   input wire logic [3:0] reg_addr, // Register address
   input wire logic [7:0] reg_wdata, // Write data
   input wire logic reg_wr, // Write strobe
   input wire logic reg_rd, // Read strobe
   output logic [7:0] reg_rdata, // Read data, cycle after strobe
   input wire logic capture_pin, // Capture input pin
   input wire logic count_input_pin, // External count pin
   output logic clock_out_pin, // Clock-out pin level
   output logic clock_out_oe, // Clock-out pin drive enable
   output logic irq // Level interrupt
);
   reg_req_t req;
   timer_event_t ev;
   timer_mode_t mode;
   logic [7:0] timer_two_control;
   logic [1:0] timer_two_mode;
   logic [7:0] reload_low;
   logic [7:0] reload_high;
   logic [15:0] count;
   logic [1:0] pin_function_select;
   logic [2:0] irq_status;
   logic [2:0] irq_mask;
   logic [2:0] irq_set;
   logic clk_level;
   logic cap_fall;
   logic cnt_fall;
   logic int_tick;
   logic count_en;
   logic wrap;
   logic run_control;
   logic ext_trigger_enable;
   logic count_source_select;
   logic capture_reload_select;
   logic clock_out_enable;
   logic [15:0] next_count;

   assign req = '{addr: reg_addr, wdata: reg_wdata, wr: reg_wr, rd: reg_rd};

   // *********************************************
   // Control field decode
   // *********************************************
   assign run_control = timer_two_control[BIT_RUN_CONTROL];
   assign ext_trigger_enable = timer_two_control[BIT_EXT_TRIGGER_ENABLE];
   assign count_source_select = timer_two_control[BIT_COUNT_SOURCE];
   assign capture_reload_select = timer_two_control[BIT_CAPTURE_RELOAD];
   assign clock_out_enable = timer_two_mode[BIT_CLOCK_OUT_ENABLE];

   // Operating mode select
   always_comb begin
      case ({capture_reload_select, ext_trigger_enable, clock_out_enable})
         3'b110, 3'b111: mode = MODE_CAPTURE;
         3'b001, 3'b011: mode = MODE_CLOCK_OUT;
         3'b010: mode = MODE_RELOAD;
         default: mode = MODE_IDLE;
      endcase
   end

   // *********************************************
   // Pin synchronisers and count rate
   // *********************************************
   pin_edge_sync u_cap_sync (
      .clk_sys(clk_sys),
      .rstn(rstn),
      .pin(capture_pin),
      .fall(cap_fall),
      .rise()
   );

   pin_edge_sync u_cnt_sync (
      .clk_sys(clk_sys),
      .rstn(rstn),
      .pin(count_input_pin),
      .fall(cnt_fall),
      .rise()
   );

   rate_divider #(.DIVIDE(OSC_DIV)) u_div (
      .clk_sys(clk_sys),
      .rstn(rstn),
      .run(run_control),
      .tick(int_tick)
   );

   // Count enable from chosen source, gated by run control
   assign count_en = run_control && (mode != MODE_IDLE)
                     && (count_source_select ? cnt_fall : int_tick);
   assign wrap = count_en && (count == COUNT_MAX);
   assign ev.overflow = wrap;
   assign ev.capture = cap_fall && run_control && (mode == MODE_CAPTURE);

   // Next counter value, reload on clock-out or reload-mode wrap
   always_comb begin
      next_count = count;
      if (wrap && (mode == MODE_CLOCK_OUT || mode == MODE_RELOAD)) begin
         next_count = {reload_high, reload_low};
      end else if (count_en) begin
         next_count = count + 16'h0001;
      end
   end

   // *********************************************
   // Counter register
   // *********************************************
   always_ff @(posedge clk_sys) begin
      if (!rstn) begin
         count <= RESET_WORD;
      end else if (req.wr && req.addr == ADDR_COUNT_LOW) begin
         count <= {next_count[15:8], req.wdata};
      end else if (req.wr && req.addr == ADDR_COUNT_HIGH) begin
         count <= {req.wdata, next_count[7:0]};
      end else begin
         count <= next_count; // keeps counting through a capture
      end
   end

   // Reload registers, loaded by capture
   always_ff @(posedge clk_sys) begin
      if (!rstn) begin
         reload_low <= RESET_BYTE;
         reload_high <= RESET_BYTE;
      end else if (ev.capture) begin
         reload_low <= count[7:0];
         reload_high <= count[15:8];
      end else if (req.wr) begin
         if (req.addr == ADDR_RELOAD_LOW) begin
            reload_low <= req.wdata;
         end
         if (req.addr == ADDR_RELOAD_HIGH) begin
            reload_high <= req.wdata;
         end
      end
   end

   // *********************************************
   // Control, mode and pin function registers
   // *********************************************
   always_ff @(posedge clk_sys) begin
      if (!rstn) begin
         timer_two_control <= RESET_BYTE;
      end else begin
         if (req.wr && req.addr == ADDR_CONTROL) begin
            timer_two_control <= req.wdata;
         end
         // Hardware set wins over a software clear
         if (ev.capture || (wrap && mode == MODE_CAPTURE)) begin
            timer_two_control[BIT_OVERFLOW_FLAG] <= 1'b1;
         end
         if (ev.capture) begin
            timer_two_control[BIT_EXTERNAL_FLAG] <= 1'b1;
         end
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!rstn) begin
         timer_two_mode <= MODE_LOW_RESET;
         pin_function_select <= 2'h0;
      end else if (req.wr && req.addr == ADDR_MODE) begin
         timer_two_mode <= req.wdata[1:0];
      end else if (req.wr && req.addr == ADDR_PIN_FUNC) begin
         pin_function_select <= req.wdata[1:0];
      end
   end

   // *********************************************
   // Clock-out level and pin
   // *********************************************
   always_ff @(posedge clk_sys) begin
      if (!rstn) begin
         clk_level <= 1'b0;
      end else if (wrap && mode == MODE_CLOCK_OUT) begin
         clk_level <= ~clk_level;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!rstn) begin
         clock_out_pin <= 1'b0;
         clock_out_oe <= 1'b0;
      end else begin
         clock_out_pin <= clk_level;
         clock_out_oe <= (pin_function_select == PIN_FUNC_CLOCK_OUT)
                         && (mode == MODE_CLOCK_OUT);
      end
   end

   // *********************************************
   // Interrupt status and mask
   // *********************************************
   always_comb begin
      irq_set = IRQ_NONE;
      irq_set[IRQ_CAPTURE] = ev.capture;
      irq_set[IRQ_OVERFLOW] = wrap && (mode == MODE_CAPTURE);
      irq_set[IRQ_TOGGLE] = wrap && (mode == MODE_CLOCK_OUT); // status only
   end

   always_ff @(posedge clk_sys) begin
      if (!rstn) begin
         irq_status <= IRQ_NONE;
         irq_mask <= IRQ_NONE;
      end else begin
         if (req.wr && req.addr == ADDR_IRQ_MASK) begin
            irq_mask <= req.wdata[2:0];
         end
         if (req.wr && req.addr == ADDR_IRQ_STATUS) begin
            irq_status <= (irq_status & ~req.wdata[2:0]) | irq_set;
         end else begin
            irq_status <= irq_status | irq_set;
         end
      end
   end

   // Clock-out bit never reaches the line
   always_ff @(posedge clk_sys) begin
      if (!rstn) begin
         irq <= 1'b0;
      end else begin
         irq <= |(irq_status[IRQ_OVERFLOW:IRQ_CAPTURE]
                  & irq_mask[IRQ_OVERFLOW:IRQ_CAPTURE]);
      end
   end

   // *********************************************
   // Register read port
   // *********************************************
   always_ff @(posedge clk_sys) begin
      if (!rstn) begin
         reg_rdata <= RESET_BYTE;
      end else if (req.rd) begin
         case (req.addr)
            ADDR_CONTROL: reg_rdata <= timer_two_control;
            ADDR_MODE: reg_rdata <= {6'h00, timer_two_mode};
            ADDR_RELOAD_LOW: reg_rdata <= reload_low;
            ADDR_RELOAD_HIGH: reg_rdata <= reload_high;
            ADDR_COUNT_LOW: reg_rdata <= count[7:0];
            ADDR_COUNT_HIGH: reg_rdata <= count[15:8];
            ADDR_PIN_FUNC: reg_rdata <= {6'h00, pin_function_select};
            ADDR_IRQ_STATUS: reg_rdata <= {5'h00, irq_status};
            ADDR_IRQ_MASK: reg_rdata <= {5'h00, irq_mask};
            default: reg_rdata <= RESET_BYTE;
         endcase
      end else begin
         reg_rdata <= RESET_BYTE;
      end
   end

   // *********************************************
   // Checks
   // *********************************************
   sequence s_clk_wrap;
      wrap && mode == MODE_CLOCK_OUT;
   endsequence

   sequence s_capture;
      ev.capture && !(req.wr && req.addr == ADDR_RELOAD_LOW);
   endsequence

   AST_CAPTURE_COPY: assert property (@(posedge clk_sys) disable iff (!rstn)
      s_capture |=> reload_low == $past(count[7:0]) && timer_two_control[BIT_EXTERNAL_FLAG])
      else $error("capture did not copy count");
   AST_CAPTURE_IRQ: assert property (@(posedge clk_sys) disable iff (!rstn)
      ev.capture |=> irq_status[IRQ_CAPTURE] ##0 timer_two_control[BIT_OVERFLOW_FLAG])
      else $error("capture raised no interrupt");
   AST_CAP_OVERFLOW: assert property (@(posedge clk_sys) disable iff (!rstn)
      (wrap && mode == MODE_CAPTURE) |=> irq_status[IRQ_OVERFLOW])
      else $error("capture overflow raised no interrupt");
   AST_RELOAD: assert property (@(posedge clk_sys) disable iff (!rstn)
      (s_clk_wrap and !req.wr) |=> count == $past({reload_high, reload_low}))
      else $error("clock-out overflow did not reload");
   AST_TOGGLE: assert property (@(posedge clk_sys) disable iff (!rstn)
      s_clk_wrap |=> ##1 clock_out_pin != $past(clock_out_pin))
      else $error("clock-out did not toggle");
   AST_NO_CLK_IRQ: assert property (@(posedge clk_sys) disable iff (!rstn)
      (s_clk_wrap and !ev.capture) |=> !irq_status[IRQ_OVERFLOW] || $past(irq_status[IRQ_OVERFLOW]))
      else $error("clock-out overflow raised interrupt");
   AST_STOPPED: assert property (@(posedge clk_sys) disable iff (!rstn)
      !run_control && !req.wr |=> count == $past(count))
      else $error("counter moved while stopped");
   AST_HOLD_LEVEL: assert property (@(posedge clk_sys) disable iff (!rstn)
      !run_control |=> clk_level == $past(clk_level))
      else $error("clock-out moved while stopped");
   AST_PIN_GATE: assert property (@(posedge clk_sys) disable iff (!rstn)
      pin_function_select != PIN_FUNC_CLOCK_OUT |=> !clock_out_oe)
      else $error("clock-out driven without pin function");
   AST_FLAG_STICKY: assert property (@(posedge clk_sys) disable iff (!rstn)
      timer_two_control[BIT_OVERFLOW_FLAG] && !(req.wr && req.addr == ADDR_CONTROL)
      |=> timer_two_control[BIT_OVERFLOW_FLAG])
      else $error("overflow flag dropped");
   AST_INT_RATE: assert property (@(posedge clk_sys) disable iff (!rstn)
      count_en && !count_source_select |=> !count_en)
      else $error("internal count faster than divided rate");
   // Reset, pin timing, count step and interrupt line
   AST_RESET_STATE: assert property (@(posedge clk_sys)
      !rstn |=> count == RESET_WORD && timer_two_control == RESET_BYTE
         && {reload_high, reload_low} == RESET_WORD && timer_two_mode == MODE_LOW_RESET)
      else $error("reset left timer state set");
   AST_OE_MODE: assert property (@(posedge clk_sys) disable iff (!rstn)
      mode != MODE_CLOCK_OUT |=> !clock_out_oe)
      else $error("clock-out driven outside clock-out mode");
   AST_CAP_SYNC: assert property (@(posedge clk_sys) disable iff (!rstn)
      $fell(capture_pin) |-> ##2 cap_fall)
      else $error("capture pin edge not seen two cycles on");
   AST_CNT_SYNC: assert property (@(posedge clk_sys) disable iff (!rstn)
      $fell(count_input_pin) |-> ##2 cnt_fall)
      else $error("count pin edge not seen two cycles on");
   AST_CAPTURE_GATE: assert property (@(posedge clk_sys) disable iff (!rstn)
      cap_fall && mode != MODE_CAPTURE
      |=> !irq_status[IRQ_CAPTURE] || $past(irq_status[IRQ_CAPTURE]))
      else $error("capture taken outside capture mode");
   AST_CNT_STEP: assert property (@(posedge clk_sys) disable iff (!rstn)
      count_en && !wrap && !req.wr |=> count == $past(count) + 16'h0001)
      else $error("counter did not step by one");
   AST_IRQ_LINE: assert property (@(posedge clk_sys) disable iff (!rstn)
      !(|(irq_status[IRQ_OVERFLOW:IRQ_CAPTURE] & irq_mask[IRQ_OVERFLOW:IRQ_CAPTURE]))
      |=> !irq)
      else $error("interrupt raised with no unmasked capture-mode event");
endmodule : timer2_capture_clock_out
`default_nettype wire

// File: bench/pin_partner.sv
// Far-side pin model: capture and count pins, clock-out observed by the bench
`timescale 1ns/1ps
`default_nettype none
module pin_partner (
   input wire logic clk_sys, // System clock
   input wire logic cap_go, // Request one capture-pin low pulse
   input wire logic cnt_go, // Request one count-pin low pulse
   output logic capture_pin, // Capture pin level
   output logic count_input_pin // Count pin level
);
   logic [2:0] cap_cnt = 3'h0;
   logic [2:0] cnt_cnt = 3'h0;

   // Low pulses of four cycles; pins sit at their pull-up level between pulses
   always_ff @(posedge clk_sys) begin
      if (cap_go) begin
         cap_cnt <= 3'h4;
      end else if (cap_cnt != 3'h0) begin
         cap_cnt <= cap_cnt - 3'h1;
      end
      if (cnt_go) begin
         cnt_cnt <= 3'h4;
      end else if (cnt_cnt != 3'h0) begin
         cnt_cnt <= cnt_cnt - 3'h1;
      end
   end

   // Each level lasts well over two cycles, so every edge is seen once
   assign capture_pin = (cap_cnt == 3'h0);
   assign count_input_pin = (cnt_cnt == 3'h0);
endmodule : pin_partner
`default_nettype wire

// File: bench/timer2_capture_clock_out_tb.sv
// Self-checking bench for the capture and clock-out timer
`timescale 1ns/1ps
`default_nettype none
module timer2_capture_clock_out_tb;
   import t2_pkg::*;
   logic clk_sys = 1'b0;
   logic rstn = 1'b0;
   logic [3:0] reg_addr = 4'h0;
   logic [7:0] reg_wdata = 8'h00;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic [7:0] reg_rdata;
   logic capture_pin;
   logic count_input_pin;
   logic clock_out_pin;
   logic clock_out_oe;
   logic irq;
   logic cap_go = 1'b0;
   logic cnt_go = 1'b0;
   logic rd_pend = 1'b0;
   logic lvl;
   logic [15:0] exp_q[$];
   logic [15:0] mon_word;
   logic [31:0] seed = 32'h882199b3;
   logic [7:0] exp_low;
   int fail_count = 0;
   int checked = 0;
   int cycles = 0;
   int half;
   int n;

   // ***********************************
   // Clock, design and pin model
   // ***********************************
   always #5 clk_sys = ~clk_sys;

   timer2_capture_clock_out #(.OSC_DIV(2)) timer2_capture_clock_out_i (
      .clk_sys(clk_sys), .rstn(rstn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .capture_pin(capture_pin), .count_input_pin(count_input_pin),
      .clock_out_pin(clock_out_pin), .clock_out_oe(clock_out_oe), .irq(irq)
   );

   pin_partner pin_partner_i (
      .clk_sys(clk_sys), .cap_go(cap_go), .cnt_go(cnt_go),
      .capture_pin(capture_pin), .count_input_pin(count_input_pin)
   );

   // ***********************************
   // Tasks
   // ***********************************
   task automatic check(input logic [15:0] seen, input logic [15:0] expv);
      checked++;
      if (seen !== expv) begin
         fail_count++;
         $display("[ERR] %0t seen %h expected %h", $time, seen, expv);
      end
   endtask : check

   task automatic test_done();
      $display("checks %0d mismatches %0d", checked, fail_count);
      if (fail_count == 0 && checked > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask : test_done

   function automatic logic [31:0] xorshift(input logic [31:0] s);
      logic [31:0] x;
      x = s ^ (s << 13);
      x = x ^ (x >> 17);
      return x ^ (x << 5);
   endfunction : xorshift

   task automatic reg_write(input logic [3:0] a, input logic [7:0] d);
      @(posedge clk_sys);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge clk_sys);
      reg_wr <= 1'b0;
   endtask : reg_write

   // Notes the masked expectation, then strobes one read
   task automatic reg_read(input logic [3:0] a, input logic [7:0] e, input logic [7:0] m);
      exp_q.push_back({m, e});
      @(posedge clk_sys);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge clk_sys);
      reg_rd <= 1'b0;
   endtask : reg_read

   task automatic pulse(input logic cap, input int k);
      repeat (k) begin
         @(posedge clk_sys);
         cap_go <= cap;
         cnt_go <= ~cap;
         @(posedge clk_sys);
         cap_go <= 1'b0;
         cnt_go <= 1'b0;
         repeat (10) @(posedge clk_sys);
      end
   endtask : pulse

   // Cycles until the clock-out level changes, bounded
   task automatic wait_toggle(output int c);
      logic l;
      l = clock_out_pin;
      c = 0;
      while (clock_out_pin === l && c < 300) begin
         @(posedge clk_sys);
         c++;
      end
   endtask : wait_toggle

   // Read data stand in the cycle after the strobe; oldest note is compared
   always @(posedge clk_sys) begin
      if (rd_pend) begin
         mon_word = exp_q.pop_front();
         check(reg_rdata & mon_word[15:8], mon_word[7:0]);
      end
      rd_pend <= reg_rd;
   end

   // Hang guard
   always @(posedge clk_sys) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         fail_count++;
         test_done();
      end
   end

   // Main sequence
   initial begin
      repeat (8) @(posedge clk_sys);
      rstn <= 1'b1;
      check(clock_out_pin, 1'b0);
      check(irq, 1'b0);
      for (int a = 0; a < 16; a++) reg_read(a[3:0], 8'h00, 8'hff);
      // Storage, unmapped write and stopped counter
      seed = xorshift(seed);
      reg_write(ADDR_RELOAD_LOW, seed[7:0]);
      reg_write(ADDR_RELOAD_HIGH, seed[15:8]);
      reg_write(4'h9, 8'hff);
      reg_write(ADDR_CONTROL, 8'h30);
      reg_write(ADDR_COUNT_LOW, 8'ha5);
      reg_read(ADDR_RELOAD_LOW, seed[7:0], 8'hff);
      reg_read(ADDR_RELOAD_HIGH, seed[15:8], 8'hff);
      reg_read(4'h9, 8'h00, 8'hff);
      reg_read(ADDR_CONTROL, 8'h30, 8'hff);
      repeat (40) @(posedge clk_sys);
      reg_read(ADDR_COUNT_LOW, 8'ha5, 8'hff);
      // Capture mode counting external pulses
      seed = xorshift(seed);
      n = 1 + seed[1:0];
      exp_low = {1'b0, seed[14:8]} + n[7:0];
      reg_write(ADDR_IRQ_MASK, 8'h03);
      reg_write(ADDR_COUNT_LOW, {1'b0, seed[14:8]});
      reg_write(ADDR_COUNT_HIGH, 8'h12);
      reg_write(ADDR_CONTROL, 8'h0f);
      pulse(1'b0, n);
      reg_read(ADDR_COUNT_LOW, exp_low, 8'hff);
      check(irq, 1'b0);
      pulse(1'b1, 1);
      reg_read(ADDR_RELOAD_LOW, exp_low, 8'hff);
      reg_read(ADDR_RELOAD_HIGH, 8'h12, 8'hff);
      reg_read(ADDR_CONTROL, 8'h4f, 8'h7f);
      reg_read(ADDR_IRQ_STATUS, 8'h01, 8'h01);
      check(irq, 1'b1);
      pulse(1'b0, 1);
      reg_read(ADDR_COUNT_LOW, exp_low + 8'h01, 8'hff);
      reg_write(ADDR_IRQ_STATUS, 8'h07);
      reg_write(ADDR_CONTROL, 8'h0f);
      repeat (4) @(posedge clk_sys);
      check(irq, 1'b0);
      // Overflow in capture mode, sticky flag, masking
      reg_write(ADDR_COUNT_LOW, 8'hfe);
      reg_write(ADDR_COUNT_HIGH, 8'hff);
      pulse(1'b0, 2);
      reg_read(ADDR_IRQ_STATUS, 8'h02, 8'h02);
      reg_read(ADDR_CONTROL, 8'h80, 8'h80);
      check(irq, 1'b1);
      reg_write(ADDR_IRQ_MASK, 8'h00);
      repeat (4) @(posedge clk_sys);
      check(irq, 1'b0);
      reg_read(ADDR_CONTROL, 8'h80, 8'h80);
      reg_write(ADDR_CONTROL, 8'h0f);
      reg_read(ADDR_CONTROL, 8'h00, 8'h80);
      // Clock-out from the internal count rate
      reg_write(ADDR_CONTROL, 8'h00);
      reg_write(ADDR_IRQ_STATUS, 8'h07);
      reg_write(ADDR_IRQ_MASK, 8'h07);
      reg_write(ADDR_RELOAD_LOW, 8'hf0);
      reg_write(ADDR_RELOAD_HIGH, 8'hff);
      reg_write(ADDR_COUNT_LOW, 8'hff);
      reg_write(ADDR_COUNT_HIGH, 8'hff);
      reg_write(ADDR_PIN_FUNC, 8'h02);
      reg_write(ADDR_MODE, 8'h02);
      reg_write(ADDR_CONTROL, 8'h04);
      wait_toggle(half);
      wait_toggle(half);
      check(half, 16'd32);
      wait_toggle(half);
      check(half, 16'd32);
      check(clock_out_oe, 1'b1);
      reg_read(ADDR_COUNT_HIGH, 8'hff, 8'hff);
      reg_read(ADDR_IRQ_STATUS, 8'h04, 8'h04);
      check(irq, 1'b0);
      reg_write(ADDR_CONTROL, 8'h00);
      repeat (2) @(posedge clk_sys); // Let a wrap already in flight reach the pin
      lvl = clock_out_pin;
      repeat (100) @(posedge clk_sys);
      check(clock_out_pin, lvl);
      reg_write(ADDR_PIN_FUNC, 8'h00);
      repeat (3) @(posedge clk_sys);
      check(clock_out_oe, 1'b0);
      // Reload mode: wrap reloads the count, capture pin is ignored
      reg_write(ADDR_MODE, 8'h00);
      reg_write(ADDR_COUNT_LOW, 8'hff);
      reg_write(ADDR_COUNT_HIGH, 8'hff);
      reg_write(ADDR_CONTROL, 8'h0e);
      pulse(1'b0, 1);
      reg_read(ADDR_COUNT_LOW, 8'hf0, 8'hff);
      reg_read(ADDR_COUNT_HIGH, 8'hff, 8'hff);
      pulse(1'b1, 1);
      reg_read(ADDR_RELOAD_LOW, 8'hf0, 8'hff);
      reg_read(ADDR_IRQ_STATUS, 8'h00, 8'h03);
      repeat (4) @(posedge clk_sys);
      test_done();
   end
endmodule : timer2_capture_clock_out_tb
`default_nettype wire
